// *** hw/tsam_regs.svh ***
// constants for the time slot address matcher
`ifndef TSAM_REGS_SVH
`define TSAM_REGS_SVH
`define TSAM_A_MOD        5'h1e
`define TSAM_B_MOD        4'ha
`define TSAM_C_MOD        2'h3
`define TSAM_A_ONE        5'h01
`define TSAM_B_ONE        4'h1
`define TSAM_C_ONE        2'h1
`define TSAM_GATE_NS      4000
`define TSAM_READY_NS     10000
`define TSAM_CLK_NS       40
`endif

// *** hw/tsam_pkg.sv ***
// types for the time slot address matcher
package tsam_pkg;
  typedef struct packed {
    logic [4:0] a;
    logic [3:0] b;
    logic [1:0] c;
  } tsam_count_s;
  typedef enum logic [2:0] {
    TSAM_IDLE  = 3'h1,
    TSAM_CLEAR = 3'h2,
    TSAM_GATE  = 3'h4
  } tsam_state_e;
endpackage

// *** hw/tsam_sync_edge.sv ***
// two-flop synchroniser with rising edge detect
`timescale 1ns/100ps
module tsam_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
endmodule // tsam_sync_edge

// *** hw/tsam_matcher.sv ***
// slot counters, address compare and holding register
`timescale 1ns/100ps
`include "tsam_regs.svh"

// Summary of operation
// - three slot counters recycle after thirty, ten and three counts
// - common reset loads every counter with one
// - counter A, five flops, divides by thirty, stepped by group sync
// - counter A recycle steps counters B and C
// - counter B, four flops, divides by ten, returns to one
// - counter C, two flops, divides by three, returns to one
// - common reset and load clock come from the sync inputs
// - twelve-bit address is buffered and compared with counter states
// - bit 1 matches group phase, bits 2-6 match counter A
// - bits 7-10 all zero or matching counter B satisfy that field
// - logic active high except the active-low reset rst_b, rising edges
// - bits 11-12 compare counter C, all zero matches any count
// - transfer needs all matches, data request and in-sync
// - clear holding register, later gate data, stretch data ready
module tsam_matcher #(
  parameter int DATA_W = 10,
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              group_sync,
  input  wire logic              frame_sync,
  input  wire logic              group_phase,
  input  wire logic              data_request,
  input  wire logic [ADDR_W-1:0] slot_addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      hold_data,
  output logic                   data_ready,
  output logic                   in_sync,
  output tsam_pkg::tsam_count_s  count
);
  localparam int GATE_CYC  = (`TSAM_GATE_NS + `TSAM_CLK_NS - 1) / `TSAM_CLK_NS;
  localparam int READY_CYC = (`TSAM_READY_NS + `TSAM_CLK_NS - 1) / `TSAM_CLK_NS;

  logic              step;
  logic              frame_rise;
  logic              phase_s;
  logic              req_s;
  logic              req_m;
  logic              phase_m;
  logic [ADDR_W-1:0] addr_m;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_m;
  logic [DATA_W-1:0] data_s;
  logic              a_wrap;
  logic              match_a;
  logic              or_b;
  logic              or_c;
  logic              fire;
  logic              armed_reg;
  logic [7:0]        dly_reg;
  logic [8:0]        rdy_reg;
  tsam_pkg::tsam_state_e state_reg;

  // sync edges give step and reset
  tsam_sync_edge u_grp (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (group_sync),
    .level   (),
    .rise    (step)
  );
  tsam_sync_edge u_frm (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  (frame_sync),
    .level   (),
    .rise    (frame_rise)
  );

  // buffer address, request and data through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_m  <= '0;
      addr_s  <= '0;
      data_m  <= '0;
      data_s  <= '0;
      req_m   <= 1'b0;
      req_s   <= 1'b0;
      phase_m <= 1'b0;
      phase_s <= 1'b0;
    end else begin
      addr_m  <= slot_addr;
      addr_s  <= addr_m;
      data_m  <= data_in;
      data_s  <= data_m;
      req_m   <= data_request;
      req_s   <= req_m;
      phase_m <= group_phase;
      phase_s <= phase_m;
    end
  end

  assign a_wrap = step && (count.a == `TSAM_A_MOD);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count.a <= `TSAM_A_ONE;
      count.b <= `TSAM_B_ONE;
      count.c <= `TSAM_C_ONE;
    end else if (frame_rise) begin
      count.a <= `TSAM_A_ONE;
      count.b <= `TSAM_B_ONE;
      count.c <= `TSAM_C_ONE;
    end else if (step) begin
      count.a <= a_wrap ? `TSAM_A_ONE : count.a + `TSAM_A_ONE;
      if (a_wrap) begin
        count.b <= (count.b == `TSAM_B_MOD) ? `TSAM_B_ONE : count.b + `TSAM_B_ONE;
        count.c <= (count.c == `TSAM_C_MOD) ? `TSAM_C_ONE : count.c + `TSAM_C_ONE;
      end
    end
  end

  // in sync once a frame reset has been seen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sync <= 1'b0;
    end else if (frame_rise) begin
      in_sync <= 1'b1;
    end
  end

  assign match_a = (addr_s[0] == phase_s) && (addr_s[5:1] == count.a);
  // comparator B or zero detector one
  assign or_b = (addr_s[9:6] == 4'h0) || (addr_s[9:6] == count.b);
  // comparator C or zero detector two
  assign or_c = (addr_s[11:10] == 2'h0) || (addr_s[11:10] == count.c);
  // data entry gate, one transfer per slot
  assign fire = match_a && or_b && or_c && req_s && in_sync && armed_reg
                && (state_reg == tsam_pkg::TSAM_IDLE);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b1;
    end else if (step) begin
      armed_reg <= 1'b1;
    end else if (fire) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= tsam_pkg::TSAM_IDLE;
      dly_reg   <= 8'h00;
    end else begin
      case (state_reg)
        tsam_pkg::TSAM_IDLE: begin
          if (fire) begin
            state_reg <= tsam_pkg::TSAM_CLEAR;
            dly_reg   <= 8'(GATE_CYC - 1);
          end
        end
        tsam_pkg::TSAM_CLEAR: begin
          if (dly_reg == 8'h00) begin
            state_reg <= tsam_pkg::TSAM_GATE;
          end else begin
            dly_reg <= dly_reg - 8'h01;
          end
        end
        tsam_pkg::TSAM_GATE: state_reg <= tsam_pkg::TSAM_IDLE;
        default: state_reg <= tsam_pkg::TSAM_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_data <= '0;
    end else if (fire) begin
      hold_data <= '0;
    end else if (state_reg == tsam_pkg::TSAM_GATE) begin
      hold_data <= data_s;
    end
  end

  // stretched ready, retriggered by each gate pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_reg <= 9'h000;
    end else if (state_reg == tsam_pkg::TSAM_GATE) begin
      rdy_reg <= 9'(READY_CYC);
    end else if (rdy_reg != 9'h000) begin
      rdy_reg <= rdy_reg - 9'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= (state_reg == tsam_pkg::TSAM_GATE) || (rdy_reg > 9'h001);
    end
  end

  b_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count.b >= `TSAM_B_ONE && count.b <= `TSAM_B_MOD)
    else $error("counter b out of range");
  a_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count.a >= `TSAM_A_ONE && count.a <= `TSAM_A_MOD)
    else $error("counter a out of range");
  c_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count.c >= `TSAM_C_ONE && count.c <= `TSAM_C_MOD)
    else $error("counter c out of range");
  a_recycle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (step && !frame_rise && count.a == `TSAM_A_MOD) |=> count.a == `TSAM_A_ONE)
    else $error("counter a did not recycle");
  bc_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!frame_rise && !a_wrap) |=> $stable(count.b) && $stable(count.c))
    else $error("counter b or c moved without a wrap");
  com_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    frame_rise |=> count.a == `TSAM_A_ONE && count.b == `TSAM_B_ONE
                   && count.c == `TSAM_C_ONE)
    else $error("common reset did not load one");
  no_unsync_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !in_sync |-> state_reg == tsam_pkg::TSAM_IDLE && !data_ready)
    else $error("transfer while unsynchronised");
  clear_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fire |=> hold_data == '0 ##[1:200] state_reg == tsam_pkg::TSAM_GATE)
    else $error("clear not followed by gate");
  zero_wild_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (addr_s[11:10] == 2'h0) |-> or_c)
    else $error("zero detector two did not match");
  ready_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg == tsam_pkg::TSAM_GATE |=> data_ready [*8])
    else $error("data ready not stretched");

  fire_c: cover property (@(posedge sys_clk) disable iff (!rst_b) fire);
  wild_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    fire && addr_s[9:6] == 4'h0);
  wrap_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    a_wrap && count.c == `TSAM_C_MOD);
endmodule // tsam_matcher

// *** bench/tsam_far_end.sv ***
// far-end timing source: one frame sync, then group sync pulses
`timescale 1ns/100ps
module tsam_far_end (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [9:0] gap,
  output logic            group_sync,
  output logic            frame_sync
);
  logic [9:0] tick_reg;
  logic       framed_reg;
  // pulses last 4 cycles so the two-flop input stage cannot miss them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_reg   <= 10'h000;
      framed_reg <= 1'b0;
      group_sync <= 1'b0;
      frame_sync <= 1'b0;
    end else if (run) begin
      tick_reg   <= (tick_reg >= gap - 10'h001) ? 10'h000 : tick_reg + 10'h001;
      frame_sync <= !framed_reg && tick_reg < 10'h004;
      group_sync <= framed_reg && tick_reg < 10'h004;
      if (tick_reg == gap - 10'h001) framed_reg <= 1'b1;
    end
  end
endmodule // tsam_far_end

// *** bench/tsam_matcher_test.sv ***
// self-checking bench for the slot address matcher
`timescale 1ns/100ps
`include "tsam_regs.svh"
module tsam_matcher_test;
  logic sys_clk, rst_b, group_sync, frame_sync, group_phase, data_request, run, gs_q, fs_q;
  logic [11:0] slot_addr;
  logic [9:0] data_in, hold_data, gap;
  logic data_ready, in_sync;
  tsam_pkg::tsam_count_s count;
  logic [4:0] exp_a;
  logic [3:0] exp_b;
  logic [1:0] exp_c;
  int n_fail = 0;
  int cmp_count = 0;
  tsam_matcher #(.DATA_W(10), .ADDR_W(12)) tsam_matcher_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .group_sync(group_sync), .frame_sync(frame_sync), .group_phase(group_phase),
    .data_request(data_request), .slot_addr(slot_addr), .data_in(data_in),
    .hold_data(hold_data), .data_ready(data_ready), .in_sync(in_sync), .count(count));
  tsam_far_end tsam_far_end_i (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .gap(gap),
    .group_sync(group_sync), .frame_sync(frame_sync));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    gs_q <= group_sync;
    fs_q <= frame_sync;
    if (!rst_b || (frame_sync && !fs_q)) begin
      exp_a <= `TSAM_A_ONE;
      exp_b <= `TSAM_B_ONE;
      exp_c <= `TSAM_C_ONE;
    end else if (group_sync && !gs_q) begin
      exp_a <= (exp_a == `TSAM_A_MOD) ? `TSAM_A_ONE : exp_a + 5'h01;
      if (exp_a == `TSAM_A_MOD) begin
        exp_b <= (exp_b == `TSAM_B_MOD) ? `TSAM_B_ONE : exp_b + 4'h1;
        exp_c <= (exp_c == `TSAM_C_MOD) ? `TSAM_C_ONE : exp_c + 2'h1;
      end
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // waits out one group pulse, then lets the two-flop stage settle
  task automatic wait_step();
    int n;
    n = 0;
    while (group_sync !== 1'b1 && n < 2000) begin @(posedge sys_clk); n++; end
    while (group_sync === 1'b1 && n < 2000) begin @(posedge sys_clk); n++; end
    repeat (6) @(posedge sys_clk);
    #1;
    check(32'(n < 2000), 32'h1, "group step seen");
  endtask
  task automatic t_unsync();
    @(posedge sys_clk);
    slot_addr <= {2'h1, 4'h1, 5'h01, 1'b1};
    data_request <= 1'b1;
    repeat (40) @(posedge sys_clk);
    #1;
    check(32'(data_ready), 32'h0, "ready while unsynced");
    check(32'(hold_data), 32'h0, "hold while unsynced");
    @(posedge sys_clk);
    data_request <= 1'b0;
    $display("test unsync done");
  endtask
  task automatic t_count();
    @(posedge sys_clk);
    run <= 1'b1;
    for (int i = 0; i < 330; i++) begin
      wait_step();
      check(32'(count), 32'({exp_a, exp_b, exp_c}), "slot count");
    end
    check(32'(in_sync), 32'h1, "in sync after frame");
    $display("test count done");
  endtask
  task automatic xfer(input logic [1:0] c, input logic [3:0] b, input logic ph,
                      input logic [9:0] d, input logic fire);
    logic [4:0] tgt;
    logic       z;
    int         n;
    // target two slots ahead, wrapping inside one to thirty
    tgt = (exp_a > `TSAM_A_MOD - 5'h02) ? exp_a + 5'h02 - `TSAM_A_MOD : exp_a + 5'h02;
    z = 1'b0;
    n = 0;
    @(posedge sys_clk);
    gap <= 10'h190;
    slot_addr <= {c, b, tgt, ph};
    data_in <= d;
    data_request <= 1'b1;
    while (data_ready !== 1'b1 && n < 1400) begin
      @(posedge sys_clk);
      #1;
      if (hold_data === 10'h000) z = 1'b1;
      n++;
    end
    check(32'(data_ready), 32'(fire), "transfer fired");
    if (fire) begin
      check(32'(z), 32'h1, "cleared first");
      check(32'(hold_data), 32'(d), "held word");
      check(32'(count.a), 32'(tgt), "slot of transfer");
      @(posedge sys_clk);
      data_request <= 1'b0;
      repeat (200) @(posedge sys_clk);
      #1;
      check(32'(data_ready), 32'h1, "ready stretched");
      repeat (60) @(posedge sys_clk);
      #1;
      check(32'(data_ready), 32'h0, "ready stretch ended");
    end else begin
      @(posedge sys_clk);
      data_request <= 1'b0;
    end
    wait_step();
    $display("test transfer %h done", d);
  endtask
  initial begin
    rst_b = 1'b0;
    run = 1'b0;
    gap = 10'h014;
    group_phase = 1'b1;
    data_request = 1'b0;
    slot_addr = 12'h000;
    data_in = 10'h000;
    repeat (16) @(posedge sys_clk);
    #1;
    check(32'(count), 32'({5'h01, 4'h1, 2'h1}), "reset count");
    check(32'({data_ready, in_sync, hold_data}), 32'h0, "reset outputs");
    @(posedge sys_clk);
    rst_b <= 1'b1;
    t_unsync();
    t_count();
    xfer(2'h0, 4'h0, 1'b1, 10'h15a, 1'b1);
    xfer(exp_c, exp_b, 1'b1, 10'h2c3, 1'b1);
    xfer(exp_c, exp_b, 1'b0, 10'h0f0, 1'b0);
    xfer(exp_c, exp_b % 4'ha + 4'h1, 1'b1, 10'h33c, 1'b0);
    xfer(exp_c % 2'h3 + 2'h1, 4'h0, 1'b1, 10'h0a5, 1'b0);
    // phase bit follows the group phase input when it is low
    @(posedge sys_clk);
    group_phase <= 1'b0;
    xfer(exp_c, exp_b, 1'b0, 10'h1e7, 1'b1);
    complete_run();
  end
  // covers the whole run with ample margin
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule // tsam_matcher_test
